// ---- core/uart_lsr_pkg.sv ----
// constants for the line status flag block
// What this block does
// [RQ1] FIFO mode: bit 7 set while any held receive character carries parity, framing or break error.
// [RQ2] Reading the line status register clears bit 7.
// [RQ3] Non-FIFO mode: bit 6 set only while holding and shift registers are empty.
// [RQ4] Bit 6 low whenever holding or shift register holds a character.
// [RQ5] FIFO mode: bit 6 set only when transmit FIFO and shift register are empty.
// [RQ6] Non-FIFO mode: bit 5 set when holding character moves into shift register.
// [RQ7] Non-FIFO mode: bit 5 clears in the cycle after the host writes the holding register.
// [RQ8] Interrupt requested while bit 5 set and its enable is on.
// [RQ9] FIFO mode: bit 5 set when transmit FIFO empties, cleared by one written byte.
// [RQ10] Bit 4 set when serial input stays low for one frame time.
// [RQ11] FIFO mode: one break character stored per break, however long it lasts.
// [RQ12] After reset bits 7, 4 and 3 read zero.
// [RQ13] Bit 3 flags missing stop bit, for the character at FIFO top.
// [RQ14] Bit 2 flags bad parity, for the character at FIFO top.
// [RQ15] Bit 1 set when a character completes with FIFO full; FIFO left unchanged.
// [RQ16] Bit 0 set while a received character waits.
// [RQ17] Reading the status register clears break, framing, parity and overrun flags.
package uart_lsr_pkg;
  // apb register byte addresses
  localparam logic [11:0] ADDR_DATA = 12'h000;
  localparam logic [11:0] ADDR_LSR = 12'h004;
  localparam logic [11:0] ADDR_CTRL = 12'h008;
  localparam logic [11:0] ADDR_FRAME = 12'h00c;
  // line status bit positions
  localparam int LSR_DR = 0;
  localparam int LSR_OE = 1;
  localparam int LSR_PE = 2;
  localparam int LSR_FE = 3;
  localparam int LSR_BI = 4;
  localparam int LSR_THRE = 5;
  localparam int LSR_TEMT = 6;
  localparam int LSR_FERR = 7;
  // control register fields and reset values
  localparam int CTRL_FIFO_EN = 0;
  localparam int CTRL_THRE_IEN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [15:0] FRAME_RESET = 16'h01b2;
  // fifo geometry and receive entry layout
  localparam int FIFO_DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int CNT_W = 7;
  localparam int RX_W = 11;
  localparam int RX_PE = 8;
  localparam int RX_FE = 9;
  localparam int RX_BI = 10;
endpackage

// ---- core/lsr_fifo.sv ----
// synchronous fifo used for the receive and transmit paths
`timescale 1ns/1ns
module lsr_fifo #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic clr_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic pop_i,
  output logic [WIDTH-1:0] top_o,
  output logic [uart_lsr_pkg::CNT_W-1:0] count_o
);
  logic [WIDTH-1:0] mem [uart_lsr_pkg::FIFO_DEPTH];
  logic [uart_lsr_pkg::PTR_W-1:0] wr_q;
  logic [uart_lsr_pkg::PTR_W-1:0] rd_q;
  logic [uart_lsr_pkg::CNT_W-1:0] cnt_q;
  wire do_push = push_i && (cnt_q != uart_lsr_pkg::CNT_W'(uart_lsr_pkg::FIFO_DEPTH));
  wire do_pop = pop_i && (cnt_q != '0);

  assign top_o = mem[rd_q];
  assign count_o = cnt_q;

  // storage, written only on an accepted push
  always_ff @(posedge clk_i) begin
    if (en_i && do_push && !clr_i) begin
      mem[wr_q] <= wdata_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (en_i) begin
      if (clr_i) begin
        wr_q <= '0;
        rd_q <= '0;
        cnt_q <= '0;
      end else begin
        wr_q <= wr_q + PTR_ONE(do_push);
        rd_q <= rd_q + PTR_ONE(do_pop);
        cnt_q <= cnt_q + CNT_W_ONE(do_push) - CNT_W_ONE(do_pop);
      end
    end
  end

  function automatic logic [uart_lsr_pkg::PTR_W-1:0] PTR_ONE(input logic b);
    PTR_ONE = {{(uart_lsr_pkg::PTR_W-1){1'b0}}, b};
  endfunction

  function automatic logic [uart_lsr_pkg::CNT_W-1:0] CNT_W_ONE(input logic b);
    CNT_W_ONE = {{(uart_lsr_pkg::CNT_W-1){1'b0}}, b};
  endfunction
endmodule

// ---- core/lsr_break_detect.sv ----
// serial line low-time watcher, one pulse per break condition
`timescale 1ns/1ns
module lsr_break_detect (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic rxd_i,
  input wire logic [15:0] frame_cycles_i,
  output logic break_o
);
  logic sync1_q;
  logic sync2_q;
  logic [15:0] low_q;
  logic fired_q;
  wire reached = (low_q >= frame_cycles_i);

  // two-stage synchroniser on the pin, counter and one-shot
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      low_q <= '0;
      fired_q <= 1'b0;
      break_o <= 1'b0;
    end else if (en_i) begin
      sync1_q <= rxd_i;
      sync2_q <= sync1_q;
      break_o <= 1'b0;
      if (sync2_q) begin
        low_q <= '0;
        fired_q <= 1'b0; // line released, arm for the next break
      end else if (!reached) begin
        low_q <= low_q + 16'h0001;
      end else if (!fired_q) begin
        fired_q <= 1'b1; // [RQ11]
        break_o <= 1'b1; // [RQ10]
      end
    end
  end
endmodule

// ---- core/uart_line_status_logic.sv ----
// line status flags, tx holding path and rx fifo for one serial channel
`timescale 1ns/1ns
module uart_line_status_logic (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // receiver side, same clock
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_parity_err_i,
  input wire logic rx_frame_err_i,
  input wire logic rxd_i,
  // transmitter side, same clock
  input wire logic tx_busy_i,
  output logic tx_load_o,
  output logic [7:0] tx_data_o,
  output logic tx_irq_o
);
  localparam int CNT_W_T = uart_lsr_pkg::CNT_W;
  logic [1:0] ctrl_q;
  logic [15:0] frame_q;
  logic oe_q;
  logic top_seen_q;
  logic top_dirty_q;
  logic ferr_seen_q;
  logic ferr_dirty_q;
  logic [CNT_W_T-1:0] err_cnt_q;
  logic rd_valid_q;
  logic lsr_oe_shown_q;
  logic [31:0] prdata_q;
  logic tx_load_q;
  logic [7:0] tx_data_q;

  // fifo ports
  logic [uart_lsr_pkg::RX_W-1:0] rx_top;
  logic [CNT_W_T-1:0] rx_cnt;
  logic [7:0] tx_top;
  logic [CNT_W_T-1:0] tx_cnt;
  logic brk_pulse;

  // apb phases
  wire setup = psel_i && !penable_i;
  wire access = psel_i && penable_i;

  // address decode, every register one aligned word
  wire hit_data = (paddr_i == uart_lsr_pkg::ADDR_DATA);
  wire hit_lsr = (paddr_i == uart_lsr_pkg::ADDR_LSR);
  wire hit_ctrl = (paddr_i == uart_lsr_pkg::ADDR_CTRL);
  wire hit_frame = (paddr_i == uart_lsr_pkg::ADDR_FRAME);
  wire mapped = hit_data || hit_lsr || hit_ctrl || hit_frame;

  // access kinds that carry side effects
  wire wr_data = access && pwrite_i && hit_data;
  wire wr_ctrl = access && pwrite_i && hit_ctrl;
  wire wr_frame = access && pwrite_i && hit_frame;
  wire rd_lsr = access && !pwrite_i && hit_lsr;
  wire rd_data = access && !pwrite_i && hit_data;

  // mode and capacity: outside fifo mode each path holds one character
  wire fifo_en = ctrl_q[uart_lsr_pkg::CTRL_FIFO_EN];
  wire thre_ien = ctrl_q[uart_lsr_pkg::CTRL_THRE_IEN];
  wire mode_chg = wr_ctrl && (pwdata_i[uart_lsr_pkg::CTRL_FIFO_EN] != fifo_en);
  wire [CNT_W_T-1:0] cap = fifo_en ? CNT_W_T'(uart_lsr_pkg::FIFO_DEPTH) : CNT_W_T'(1);
  wire rx_empty = (rx_cnt == '0);
  wire rx_full = (rx_cnt >= cap);
  wire tx_empty = (tx_cnt == '0);
  wire tx_full = (tx_cnt >= cap);

  // receive pushes: a break character wins the slot over a normal character
  wire rx_new = rx_valid_i || brk_pulse;
  // a break is stored as a zero character marked with break and framing error
  wire [uart_lsr_pkg::RX_W-1:0] brk_entry = (uart_lsr_pkg::RX_W'(1) << uart_lsr_pkg::RX_BI)
                                           | (uart_lsr_pkg::RX_W'(1) << uart_lsr_pkg::RX_FE); // [RQ11]
  wire [uart_lsr_pkg::RX_W-1:0] rx_entry = brk_pulse ? brk_entry
                                          : {1'b0, rx_frame_err_i, rx_parity_err_i, rx_data_i};
  wire rx_push = rx_new && !rx_full; // [RQ15]
  wire rx_ovr = rx_new && rx_full; // [RQ15]
  wire rx_pop = rd_data && rd_valid_q;

  // error bookkeeping: errored entries coming in, going out, top replaced
  wire new_err = rx_push && (rx_entry[uart_lsr_pkg::RX_BI:uart_lsr_pkg::RX_PE] != 3'h0);
  wire top_err = !rx_empty && (rx_top[uart_lsr_pkg::RX_BI:uart_lsr_pkg::RX_PE] != 3'h0);
  wire old_err = rx_pop && top_err;
  wire top_chg = rx_pop || (rx_push && rx_empty);

  // transmit path: host writes fill, an idle shifter drains
  wire tx_push = wr_data && !tx_full;
  wire tx_pop = !tx_empty && !tx_busy_i && !tx_load_q;

  // status bits
  wire flag_dr = !rx_empty; // [RQ16]
  wire flags_on = !rx_empty && !top_seen_q;
  wire flag_pe = flags_on && rx_top[uart_lsr_pkg::RX_PE]; // [RQ14]
  wire flag_fe = flags_on && rx_top[uart_lsr_pkg::RX_FE]; // [RQ13]
  wire flag_bi = flags_on && rx_top[uart_lsr_pkg::RX_BI]; // [RQ10]
  wire flag_ferr = fifo_en && (err_cnt_q != '0) && !ferr_seen_q; // [RQ1]

  // transmit flags: the holding path, then holding path plus shifter
  wire flag_thre = tx_empty; // [RQ6] [RQ7] [RQ9]
  wire flag_temt = tx_empty && !tx_busy_i && !tx_load_q; // [RQ3] [RQ4] [RQ5]

  // status word in register bit order
  wire [7:0] lsr_val = {flag_ferr, flag_temt, flag_thre, flag_bi, flag_fe, flag_pe, oe_q, flag_dr};

  // read words, unused upper bits read as zero
  wire [31:0] data_word = {24'h000000, rx_empty ? 8'h00 : rx_top[7:0]};
  wire [31:0] lsr_word = {24'h000000, lsr_val};
  wire [31:0] ctrl_word = {30'h0, ctrl_q};
  wire [31:0] frame_word = {16'h0000, frame_q};

  // read mux, sampled in the setup cycle
  wire [31:0] rd_mux = hit_data ? data_word
                     : hit_lsr ? lsr_word
                     : hit_ctrl ? ctrl_word
                     : hit_frame ? frame_word
                     : 32'h00000000;

  // bus answers at once; load strobe and tx data come straight from flip-flops, the interrupt is decoded
  assign pready_o = 1'b1;
  assign pslverr_o = access && !mapped;
  assign prdata_o = prdata_q;
  assign tx_load_o = tx_load_q;
  assign tx_data_o = tx_data_q;
  assign tx_irq_o = flag_thre && thre_ien; // [RQ8]

  // receive fifo, entries hold data plus break, framing and parity marks
  lsr_fifo #(
    .WIDTH(uart_lsr_pkg::RX_W)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(ce_i),
    .clr_i(mode_chg),
    .push_i(rx_push),
    .wdata_i(rx_entry),
    .pop_i(rx_pop),
    .top_o(rx_top),
    .count_o(rx_cnt)
  );

  // transmit fifo, a single holding register outside fifo mode
  lsr_fifo #(
    .WIDTH(8)
  ) u_tx_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(ce_i),
    .clr_i(mode_chg),
    .push_i(tx_push),
    .wdata_i(pwdata_i[7:0]),
    .pop_i(tx_pop),
    .top_o(tx_top),
    .count_o(tx_cnt)
  );

  // break watcher on the serial input
  lsr_break_detect u_brk (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(ce_i),
    .rxd_i(rxd_i),
    .frame_cycles_i(frame_q),
    .break_o(brk_pulse)
  );

  // control register: fifo enable and tx-empty interrupt enable
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= uart_lsr_pkg::CTRL_RESET;
    end else if (ce_i && wr_ctrl) begin
      ctrl_q <= pwdata_i[1:0];
    end
  end

  // frame length in clock cycles, the break detection time
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_q <= uart_lsr_pkg::FRAME_RESET;
    end else if (ce_i && wr_frame) begin
      frame_q <= pwdata_i[15:0];
    end
  end

  // read data capture, taken in the setup cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_q <= '0;
    end else if (ce_i && setup) begin
      prdata_q <= rd_mux;
    end
  end

  // what the captured word showed, so the access clears only that
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_valid_q <= 1'b0;
      lsr_oe_shown_q <= 1'b0;
    end else if (ce_i && setup) begin
      rd_valid_q <= !rx_empty;
      lsr_oe_shown_q <= oe_q;
    end
  end

  // overrun: sticky, an event in the clearing cycle wins
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oe_q <= 1'b0;
    end else if (ce_i) begin
      if (rx_ovr) begin
        oe_q <= 1'b1; // [RQ15]
      end else if (rd_lsr && lsr_oe_shown_q) begin
        oe_q <= 1'b0; // [RQ17]
      end
    end
  end

  // top-of-fifo error marks hide once read, reappear for the next top
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      top_seen_q <= 1'b0; // [RQ12]
    end else if (ce_i) begin
      if (top_chg || mode_chg) begin
        top_seen_q <= 1'b0;
      end else if (rd_lsr && !top_dirty_q) begin
        top_seen_q <= 1'b1; // [RQ17]
      end
    end
  end

  // top moved after the status was sampled, so the read must not hide it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      top_dirty_q <= 1'b0;
    end else if (ce_i) begin
      if (setup) begin
        top_dirty_q <= 1'b0;
      end else if (top_chg) begin
        top_dirty_q <= 1'b1;
      end
    end
  end

  // count of errored characters held in the receive fifo
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_cnt_q <= '0;
    end else if (ce_i) begin
      if (mode_chg) begin
        err_cnt_q <= '0;
      end else begin
        err_cnt_q <= err_cnt_q + CNT_W_T'(new_err) - CNT_W_T'(old_err); // [RQ1]
      end
    end
  end

  // read-clear mask of the fifo error flag, a new error wins over the read
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ferr_seen_q <= 1'b0; // [RQ12]
    end else if (ce_i) begin
      if (new_err || mode_chg) begin
        ferr_seen_q <= 1'b0;
      end else if (rd_lsr && !ferr_dirty_q) begin
        ferr_seen_q <= 1'b1; // [RQ2]
      end
    end
  end

  // an errored character stored after the status was sampled
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ferr_dirty_q <= 1'b0;
    end else if (ce_i) begin
      if (setup) begin
        ferr_dirty_q <= 1'b0;
      end else if (new_err) begin
        ferr_dirty_q <= 1'b1;
      end
    end
  end

  // hand the next character to the shifter, a one-cycle load strobe
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_load_q <= 1'b0;
    end else if (ce_i) begin
      tx_load_q <= tx_pop; // [RQ6]
    end
  end

  // character for the shifter, held after the strobe
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_data_q <= '0;
    end else if (ce_i && tx_pop) begin
      tx_data_q <= tx_top;
    end
  end
endmodule

// ---- tb/uart_lsr_props.sv ----
// port-level assertions for the line status block
`timescale 1ns/1ns
module uart_lsr_props (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic tx_busy_i,
  input wire logic tx_load_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i || !ce_i);
  // access phase and address map decode
  wire acc = psel_i && penable_i;
  wire mapped = paddr_i[11:4] == 8'h00 && paddr_i[1:0] == 2'h0;
  // status read and data write access phases
  sequence s_lsr_rd;
    acc && !pwrite_i && paddr_i == uart_lsr_pkg::ADDR_LSR;
  endsequence
  sequence s_data_wr;
    acc && pwrite_i && paddr_i == uart_lsr_pkg::ADDR_DATA;
  endsequence
  chk_no_wait: assert property (psel_i |-> pready_o) else $error("wait state seen");
  chk_slverr_map: assert property (pslverr_o == (acc && !mapped)) else $error("slave error mismatch");
  chk_load_gap: assert property (tx_load_o |=> !tx_load_o) else $error("load pulses adjacent");
  chk_load_idle: assert property (tx_load_o |-> !$past(tx_busy_i)) else $error("load while busy");
  chk_data_hold: assert property (!tx_load_o |-> $stable(tx_data_o)) else $error("tx data moved");
  chk_irq_write: assert property (s_data_wr |=> !tx_irq_o) else $error("irq after write");
  chk_irq_thre: assert property (s_lsr_rd ##0 $past(tx_irq_o) |-> prdata_o[5])
    else $error("irq without holding empty");
  chk_temt_busy: assert property (s_lsr_rd ##0 prdata_o[6] |-> !$past(tx_busy_i) && !$past(tx_load_o))
    else $error("tx empty while shifting");
  chk_temt_thre: assert property (s_lsr_rd |-> !prdata_o[6] || prdata_o[5])
    else $error("tx empty without holding empty");
endmodule
bind uart_line_status_logic uart_lsr_props i_uart_lsr_props (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_busy_i(tx_busy_i), .tx_load_o(tx_load_o),
  .tx_data_o(tx_data_o), .tx_irq_o(tx_irq_o));

// ---- tb/tx_shift_model.sv ----
// transmit shifter model: busy for a fixed time after each load
`timescale 1ns/1ns
module tx_shift_model #(
  parameter int BUSY_CYC = 20
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic load_i,
  input wire logic [7:0] data_i,
  output logic busy_o,
  output logic [7:0] last_o,
  output logic [7:0] count_o
);
  logic [7:0] left_q;
  // take a byte on load, then count down the shift time
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      left_q <= 8'h00;
      last_o <= 8'h00;
      count_o <= 8'h00;
    end else if (load_i) begin
      left_q <= 8'(BUSY_CYC);
      last_o <= data_i;
      count_o <= count_o + 8'h01;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  assign busy_o = left_q != 8'h00;
endmodule

// ---- tb/uart_line_status_logic_tb_top.sv ----
// testbench for the line status block
`timescale 1ns/1ns
module uart_line_status_logic_tb_top;
  logic clk = 1'h0, rstn = 1'h0, ce = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic rx_valid = 1'h0, rx_pe = 1'h0, rx_fe = 1'h0, rxd = 1'h1;
  logic pready, pslverr, busy, load, irq, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [7:0] rx_data = 8'h00, txd, last, cnt;
  int bad_count = 0;
  int compares = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  uart_line_status_logic i_uart_line_status_logic (.clk_i(clk), .rstn_i(rstn), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .rx_parity_err_i(rx_pe), .rx_frame_err_i(rx_fe), .rxd_i(rxd), .tx_busy_i(busy), .tx_load_o(load),
    .tx_data_o(txd), .tx_irq_o(irq));
  tx_shift_model #(.BUSY_CYC(20)) i_tx_shift_model (.clk_i(clk), .rstn_i(rstn), .load_i(load),
    .data_i(txd), .busy_o(busy), .last_o(last), .count_o(cnt));
  // verdict and compare helpers
  task automatic give_verdict;
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one apb transfer, entered right after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    r = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic chk_rd(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(name, r, exp);
  endtask
  // one received character from the receiver
  task automatic rx(input logic [7:0] d, input logic pe, input logic fe);
    rx_valid <= 1'h1;
    rx_data <= d;
    rx_pe <= pe;
    rx_fe <= fe;
    @(posedge clk);
    rx_valid <= 1'h0;
    @(posedge clk);
  endtask
  // two bytes out, the second waits behind the busy shifter
  task automatic send2(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] n;
    n = cnt;
    apb(1'h1, uart_lsr_pkg::ADDR_DATA, {24'h0, a});
    apb(1'h1, uart_lsr_pkg::ADDR_DATA, {24'h0, b});
    check("irq", irq, 32'h0);
    chk_rd("lsr", uart_lsr_pkg::ADDR_LSR, 32'h00);
    while (cnt !== n + 8'h02 || busy !== 1'h0) @(posedge clk);
    check("tx byte", last, b);
    chk_rd("lsr", uart_lsr_pkg::ADDR_LSR, 32'h60);
    check("irq", irq, 32'h1);
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    check("irq", irq, 32'h0);
    chk_rd("lsr", uart_lsr_pkg::ADDR_LSR, 32'h60);
    check("slverr", err, 32'h0);
    chk_rd("unmapped", 12'h010, 32'h0);
    check("slverr", err, 32'h1);
    apb(1'h1, uart_lsr_pkg::ADDR_FRAME, 32'h20);
    apb(1'h1, uart_lsr_pkg::ADDR_CTRL, 32'h2);
    check("irq", irq, 32'h1);
    send2(8'ha5, 8'h5a);
    rx(8'h3c, 1'h1, 1'h0);
    chk_rd("lsr", uart_lsr_pkg::ADDR_LSR, 32'h65);
    chk_rd("lsr", uart_lsr_pkg::ADDR_LSR, 32'h61);
    chk_rd("data", uart_lsr_pkg::ADDR_DATA, 32'h3c);
    rx(8'h11, 1'h0, 1'h0);
    rx(8'h22, 1'h0, 1'h0);
    chk_rd("lsr", uart_lsr_pkg::ADDR_LSR, 32'h63);
    chk_rd("lsr", uart_lsr_pkg::ADDR_LSR, 32'h61);
    chk_rd("data", uart_lsr_pkg::ADDR_DATA, 32'h11);
    chk_rd("lsr", uart_lsr_pkg::ADDR_LSR, 32'h60);
    apb(1'h1, uart_lsr_pkg::ADDR_CTRL, 32'h3);
    send2(8'hc3, 8'h3c);
    rx(8'h7e, 1'h0, 1'h1);
    chk_rd("lsr", uart_lsr_pkg::ADDR_LSR, 32'he9);
    chk_rd("lsr", uart_lsr_pkg::ADDR_LSR, 32'h61);
    chk_rd("data", uart_lsr_pkg::ADDR_DATA, 32'h7e);
    rxd <= 1'h0;
    repeat (100) @(posedge clk);
    rxd <= 1'h1;
    repeat (5) @(posedge clk);
    chk_rd("lsr", uart_lsr_pkg::ADDR_LSR, 32'hf9);
    chk_rd("data", uart_lsr_pkg::ADDR_DATA, 32'h0);
    chk_rd("lsr", uart_lsr_pkg::ADDR_LSR, 32'h60);
    // a character offered while the clock enable is low must not be taken
    ce <= 1'h0;
    rx(8'h55, 1'h0, 1'h0);
    ce <= 1'h1;
    chk_rd("frozen", uart_lsr_pkg::ADDR_LSR, 32'h60);
    give_verdict;
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict;
  end
endmodule
